// file: xy_pkg.sv
package xy_pkg;

  // bus numbering, also the arbitration order (lowest wins)
  localparam int NBUS  = 4;
  localparam int BUS_I = 0;
  localparam int BUS_L = 1;
  localparam int BUS_X = 2;
  localparam int BUS_Y = 3;

  // memory geometry: 2 banks x 2 pages of 4 kbyte words
  localparam int NUNIT      = 4;
  localparam int PAGE_IDX_W = 10;
  localparam int IDX_HI     = 11;
  localparam int IDX_LO     = 2;
  localparam int BANK_BIT   = 16;
  localparam int PAGE_BIT   = 15;

  // address decode
  localparam logic [7:0] WIN_CACHED   = 8'h05;
  localparam logic [7:0] WIN_UNCACHED = 8'hA5;
  localparam logic [6:0] REGION_HI    = 7'h00;
  localparam logic [3:0] PAGE0_NIB    = 4'h7;
  localparam logic [3:0] PAGE1_NIB    = 4'h8;

  // byte lanes, big-endian: byte 0 sits in bits 31:24
  localparam logic [3:0] BE_BYTE0 = 4'h8;
  localparam logic [3:0] BE_HI    = 4'hC;
  localparam logic [3:0] BE_LO    = 4'h3;
  localparam logic [3:0] BE_WORD  = 4'hF;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } size_t;

  typedef enum logic {
    M_IDLE = 1'b0,
    M_WAIT = 1'b1
  } mst_state_t;

  // inside the window and on a populated page, not reserved space
  function automatic logic addr_ok(input logic [31:0] a,
                                   input logic        unc);
    addr_ok = (a[31:24] == (unc ? WIN_UNCACHED : WIN_CACHED)) &&
              (a[23:17] == REGION_HI) &&
              ((a[15:12] == PAGE0_NIB) || (a[15:12] == PAGE1_NIB));
  endfunction : addr_ok

  // operand buses carry a bank-relative offset only
  function automatic logic [31:0] xy_addr(input logic        bank,
                                          input logic [15:0] off);
    xy_addr = {WIN_CACHED, REGION_HI, bank, off};
  endfunction : xy_addr

  function automatic logic [3:0] be_of(input size_t      sz,
                                       input logic [1:0] lo);
    case (sz)
      SZ_BYTE: be_of = BE_BYTE0 >> lo;
      SZ_HALF: be_of = lo[1] ? BE_LO : BE_HI;
      default: be_of = BE_WORD;
    endcase
  endfunction : be_of

endpackage : xy_pkg

// file: xy_if.sv
`timescale 1ns/1ps
interface xy_if;
  import xy_pkg::*;

  logic               req   [NBUS];
  logic               we    [NBUS];
  size_t              size  [NBUS];
  logic        [31:0] addr  [NBUS];
  logic        [31:0] wdata [NBUS];
  logic               ack   [NBUS];
  logic        [31:0] rdata [NBUS];

  modport dev (
    input  req,
    input  we,
    input  size,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport mst (
    output req,
    output we,
    output size,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface : xy_if

// file: xy_page.sv
`timescale 1ns/1ps
module xy_page #(
  parameter int IDX_W = xy_pkg::PAGE_IDX_W
) (
  // clock
  input  wire logic             clock,
  // write port
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [3:0]       wr_be,
  input  wire logic [31:0]      wr_data,
  // read port
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [31:0]      rd_data
);
  import xy_pkg::*;

  localparam int DEPTH = 1 << IDX_W;

  logic [31:0] mem [DEPTH];

  assign rd_data = mem[rd_idx];

  // one process for all lanes: the storage keeps a single writer
  always_ff @(posedge clock) begin
    for (int b = 0; b < 4; b++) begin
      if (wr_en && wr_be[b]) begin
        mem[wr_idx][8*b +: 8] <= wr_data[8*b +: 8];
      end
    end
  end
endmodule : xy_page

// file: xy_ram.sv
`timescale 1ns/1ps
// Functional notes
// - decode cached and uncached scratch windows
// - masters use only those two regions
// - read answers in one cycle, write two
// - decode region holds reserved space too
// - two banks of 8 kbytes each
// - each bank split into two pages
// - masters never touch reserved addresses
// - independent ports for system, local, operand
// - same target: system, local, then operand
// - different banks or pages run concurrently
// - cached via system bus, uncached via local
// - cpu byte, half, word on both buses
// - dma byte, half, word on system bus
// - operand buses always halfword wide
// - two operand accesses in one cycle
// - dsp single transfers use local bus
// - no cpu or dsp access during dma
// - cache on means uncached region only
module xy_ram #(
  parameter int IDX_W = xy_pkg::PAGE_IDX_W
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // the four buses
  xy_if.dev         bus
);
  import xy_pkg::*;

  // operand buses carry a bank offset and a halfword only
  function automatic logic is_operand(input int p);
    is_operand = (p >= BUS_X);
  endfunction : is_operand

  // big-endian halves: address bit 1 set picks the low half
  function automatic logic [15:0] half_of(input logic [31:0] w,
                                          input logic        sel);
    half_of = sel ? w[15:0] : w[31:16];
  endfunction : half_of

  // per bus
  logic             want   [NBUS];
  logic             hit    [NBUS];
  logic             won    [NBUS];
  logic             wpend  [NBUS];
  logic             ack    [NBUS];
  logic [1:0]       unit   [NBUS];
  logic [1:0]       lo     [NBUS];
  logic [IDX_W-1:0] idx    [NBUS];
  logic [3:0]       be     [NBUS];
  logic [31:0]      wd     [NBUS];
  logic [31:0]      rdq    [NBUS];

  // per bank page
  logic             busy    [NUNIT];
  logic             wr_take [NUNIT];
  logic             lock    [NUNIT];
  logic [1:0]       owner   [NUNIT];
  logic [IDX_W-1:0] rd_idx  [NUNIT];
  logic [IDX_W-1:0] w_idx   [NUNIT];
  logic [3:0]       w_be    [NUNIT];
  logic [31:0]      w_data  [NUNIT];
  logic [31:0]      rd_word [NUNIT];

  // address decode of every bus
  always_comb begin
    logic [31:0] a;
    a = '0;
    for (int p = 0; p < NBUS; p++) begin
      a = bus.addr[p];
      if (is_operand(p)) begin
        // operand buses reach only their own bank
        a = xy_addr(p == BUS_Y, bus.addr[p][15:0]);
      end
      // system bus serves the cached window, local the uncached one
      hit[p]  = addr_ok(a, p == BUS_L);
      unit[p] = {a[BANK_BIT], a[PAGE_BIT]};
      idx[p]  = a[IDX_HI:IDX_LO];
      lo[p]   = a[1:0];
    end
  end

  // byte lanes and write data of every bus
  always_comb begin
    for (int p = 0; p < NBUS; p++) begin
      if (is_operand(p)) begin
        be[p] = be_of(SZ_HALF, lo[p]);
        wd[p] = {2{bus.wdata[p][15:0]}};
      end else begin
        be[p] = be_of(bus.size[p], lo[p]);
        wd[p] = bus.wdata[p];
      end
    end
  end

  // a request stays pending until it is answered; a write in
  // flight masks its own port so it is never taken twice
  always_comb begin
    for (int p = 0; p < NBUS; p++) begin
      want[p] = bus.req[p] && !ack[p] && !wpend[p];
    end
  end

  // fixed priority per bank page; a page in its write cycle
  // takes nobody, which keeps the two-cycle write atomic
  always_comb begin
    for (int u = 0; u < NUNIT; u++) begin
      busy[u]  = 1'b0;
      owner[u] = 2'(BUS_I);
      for (int p = NBUS - 1; p >= 0; p--) begin
        if (want[p] && hit[p] && unit[p] == 2'(u) && !lock[u]) begin
          busy[u]  = 1'b1;
          owner[u] = 2'(p);
        end
      end
      rd_idx[u]  = idx[owner[u]];
      wr_take[u] = busy[u] && bus.we[owner[u]];
    end
    for (int p = 0; p < NBUS; p++) begin
      // reserved space is answered at once, nothing is stored
      won[p] = want[p] &&
               (!hit[p] ||
                (busy[unit[p]] && owner[unit[p]] == 2'(p)));
    end
  end

  // answers: read one edge after the grant, write two
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < NBUS; p++) begin
        ack[p]   <= 1'b0;
        wpend[p] <= 1'b0;
      end
    end else begin
      for (int p = 0; p < NBUS; p++) begin
        ack[p]   <= wpend[p] || (won[p] && !bus.we[p]);
        wpend[p] <= won[p] && bus.we[p];
      end
    end
  end

  // read data, lane-aligned; operand buses get their half low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < NBUS; p++) begin
        rdq[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NBUS; p++) begin
        if (won[p] && !bus.we[p]) begin
          if (!hit[p]) begin
            // reserved space reads as zero, never a stale word
            rdq[p] <= '0;
          end else if (is_operand(p)) begin
            rdq[p] <= {16'h0000, half_of(rd_word[unit[p]], lo[p][1])};
          end else begin
            rdq[p] <= rd_word[unit[p]];
          end
        end
      end
    end
  end

  // write capture: data lands in the page on the following edge
  // the page stays locked for that cycle, so its readers wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int u = 0; u < NUNIT; u++) begin
        lock[u]   <= 1'b0;
        w_idx[u]  <= '0;
        w_be[u]   <= '0;
        w_data[u] <= '0;
      end
    end else begin
      for (int u = 0; u < NUNIT; u++) begin
        lock[u] <= wr_take[u];
        if (wr_take[u]) begin
          w_idx[u]  <= idx[owner[u]];
          w_be[u]   <= be[owner[u]];
          w_data[u] <= wd[owner[u]];
        end
      end
    end
  end

  // one storage unit per bank page, each with its own port,
  // so both operand buses are served in the same cycle
  for (genvar u = 0; u < NUNIT; u++) begin : g_unit
    xy_page #(
      .IDX_W (IDX_W)
    ) u_page (
      .clock   (clock),
      .wr_en   (lock[u]),
      .wr_idx  (w_idx[u]),
      .wr_be   (w_be[u]),
      .wr_data (w_data[u]),
      .rd_idx  (rd_idx[u]),
      .rd_data (rd_word[u])
    );
  end

  // answers leave straight from flip-flops, no decode path outward
  for (genvar p = 0; p < NBUS; p++) begin : g_out
    assign bus.ack[p]   = ack[p];
    assign bus.rdata[p] = rdq[p];
  end
endmodule : xy_ram

// file: xy_masters.sv
`timescale 1ns/1ps
module xy_masters (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // system state
  input  wire logic          cache_on,
  input  wire logic          dma_active,
  input  wire logic          l_dsp,
  // commands
  input  wire logic          cmd_valid [xy_pkg::NBUS],
  input  wire logic          cmd_we    [xy_pkg::NBUS],
  input  xy_pkg::size_t      cmd_size  [xy_pkg::NBUS],
  input  wire logic [31:0]   cmd_addr  [xy_pkg::NBUS],
  input  wire logic [31:0]   cmd_wdata [xy_pkg::NBUS],
  output logic               cmd_ready [xy_pkg::NBUS],
  // responses
  output logic               rsp_valid [xy_pkg::NBUS],
  output logic               rsp_err   [xy_pkg::NBUS],
  output logic      [31:0]   rsp_rdata [xy_pkg::NBUS],
  // the four buses
  xy_if.mst                  bus
);
  import xy_pkg::*;

  for (genvar p = 0; p < NBUS; p++) begin : g_bus
    mst_state_t  st;
    logic        legal;
    logic        blocked;
    logic        ready_q;
    logic        vld_q;
    logic        err_q;
    logic [31:0] rd_q;
    logic        req_q;
    logic        we_q;
    size_t       size_q;
    logic [31:0] addr_q;
    logic [31:0] wd_q;

    // only the dma engine may use the memory during a dma transfer
    assign blocked = dma_active && (p != BUS_I);

    always_comb begin
      if (p == BUS_I) begin
        legal = addr_ok(cmd_addr[p], 1'b0) && !cache_on;
      end else if (p == BUS_L) begin
        legal = addr_ok(cmd_addr[p], 1'b1) &&
                !(l_dsp && cmd_size[p] == SZ_BYTE);
      end else begin
        legal = addr_ok(xy_addr(p == BUS_Y, cmd_addr[p][15:0]), 1'b0);
      end
    end

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        st      <= M_IDLE;
        ready_q <= 1'b0;
        vld_q   <= 1'b0;
        err_q   <= 1'b0;
        rd_q    <= '0;
        req_q   <= 1'b0;
        we_q    <= 1'b0;
        size_q  <= SZ_WORD;
        addr_q  <= '0;
        wd_q    <= '0;
      end else begin
        vld_q <= 1'b0;
        case (st)
          M_IDLE: begin
            ready_q <= !blocked;
            if (cmd_valid[p] && ready_q) begin
              ready_q <= 1'b0;
              if (legal) begin
                req_q  <= 1'b1;
                we_q   <= cmd_we[p];
                size_q <= (p >= BUS_X) ? SZ_HALF : cmd_size[p];
                addr_q <= cmd_addr[p];
                wd_q   <= cmd_wdata[p];
                st     <= M_WAIT;
              end else begin
                // bad region or reserved space never reaches the bus
                vld_q <= 1'b1;
                err_q <= 1'b1;
              end
            end
          end
          M_WAIT: begin
            if (bus.ack[p]) begin
              req_q <= 1'b0;
              vld_q <= 1'b1;
              err_q <= 1'b0;
              rd_q  <= bus.rdata[p];
              st    <= M_IDLE;
            end
          end
          default: st <= M_IDLE;
        endcase
      end
    end

    assign cmd_ready[p] = ready_q;
    assign rsp_valid[p] = vld_q;
    assign rsp_err[p]   = err_q;
    assign rsp_rdata[p] = rd_q;
    assign bus.req[p]   = req_q;
    assign bus.we[p]    = we_q;
    assign bus.size[p]  = size_q;
    assign bus.addr[p]  = addr_q;
    assign bus.wdata[p] = wd_q;
  end
endmodule : xy_masters

// file: xy_props.sv
`timescale 1ns/1ps
module xy_props (
  // clock and reset
  input logic          clock,
  input logic          rst,
  // bus signals
  input logic          req   [xy_pkg::NBUS],
  input logic          we    [xy_pkg::NBUS],
  input xy_pkg::size_t size  [xy_pkg::NBUS],
  input logic   [31:0] addr  [xy_pkg::NBUS],
  input logic          ack   [xy_pkg::NBUS],
  input logic   [31:0] rdata [xy_pkg::NBUS]
);
  import xy_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  for (genvar p = 0; p < NBUS; p++) begin : g_port
    ack_pulse_a:
      assert property (ack[p] |=> !ack[p])
      else $error("ack wider than one cycle");
    req_hold_a:
      assert property (req[p] && !ack[p] |=> req[p] && $stable(addr[p]))
      else $error("request changed before ack");
  end

  sys_window_a:
    assert property (req[BUS_I] |-> addr[BUS_I][31:24] == WIN_CACHED)
    else $error("system bus outside cached window");
  loc_window_a:
    assert property (req[BUS_L] |-> addr[BUS_L][31:24] == WIN_UNCACHED)
    else $error("local bus outside uncached window");
  operand_half_a:
    assert property (req[BUS_X] |-> size[BUS_X] == SZ_HALF)
    else $error("operand access not halfword");
  operand_upper_a:
    assert property (ack[BUS_Y] |-> rdata[BUS_Y][31:16] == 16'h0000)
    else $error("operand read upper half not zero");
  prio_order_a:
    assert property ($rose(req[BUS_I]) && $rose(req[BUS_L]) &&
      addr[BUS_I][16:15] == addr[BUS_L][16:15] |=> !ack[BUS_L])
    else $error("local bus beat system bus");
  sys_read_a:
    assert property ($rose(req[BUS_I]) && !we[BUS_I] |-> ##[1:3] ack[BUS_I])
    else $error("system read too slow");
  sys_write_a:
    assert property ($rose(req[BUS_I]) && we[BUS_I]
      |=> !ack[BUS_I] ##[1:3] ack[BUS_I])
    else $error("system write timing wrong");
  dual_op_a:
    assert property ($rose(req[BUS_X]) && $rose(req[BUS_Y]) &&
      !we[BUS_X] && !we[BUS_Y] |=> ack[BUS_X] && ack[BUS_Y])
    else $error("operand accesses not served together");
  bank_concur_a:
    assert property ($rose(req[BUS_I]) && $rose(req[BUS_L]) &&
      !we[BUS_I] && !we[BUS_L] &&
      addr[BUS_I][BANK_BIT:PAGE_BIT] != addr[BUS_L][BANK_BIT:PAGE_BIT]
      |=> ack[BUS_I] && ack[BUS_L])
    else $error("accesses to different pages not concurrent");
endmodule : xy_props

// file: dual_bank_multiport_ram_tb_top.sv
`timescale 1ns/1ps
module dual_bank_multiport_ram_tb_top;
  import xy_pkg::*;
  logic        clock, rst, cache_on, dma_active, l_dsp;
  logic        cmd_valid [NBUS];
  logic        cmd_we    [NBUS];
  size_t       cmd_size  [NBUS];
  logic [31:0] cmd_addr  [NBUS];
  logic [31:0] cmd_wdata [NBUS];
  logic        cmd_ready [NBUS];
  logic        rsp_valid [NBUS];
  logic        rsp_err   [NBUS];
  logic [31:0] rsp_rdata [NBUS];
  int          num_errors, comparisons;

  xy_if bus_if ();
  xy_ram u_xy_ram (.clock(clock), .rst(rst), .bus(bus_if.dev));
  xy_masters u_xy_masters (.clock(clock), .rst(rst),
    .cache_on(cache_on), .dma_active(dma_active), .l_dsp(l_dsp),
    .cmd_valid(cmd_valid), .cmd_we(cmd_we), .cmd_size(cmd_size),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
    .bus(bus_if.mst));
  xy_props u_xy_props (.clock(clock), .rst(rst), .req(bus_if.req),
    .we(bus_if.we), .size(bus_if.size), .addr(bus_if.addr),
    .ack(bus_if.ack), .rdata(bus_if.rdata));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic report_and_stop;
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_data(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_data

  task automatic check_flag(input logic got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_flag

  // fields held until the edge that sees ready, then released
  task automatic run_cmd(input int p, input logic w, input size_t s,
      input logic [31:0] a, d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clock);
    cmd_valid[p] <= 1'b1;
    cmd_we[p]    <= w;
    cmd_size[p]  <= s;
    cmd_addr[p]  <= a;
    cmd_wdata[p] <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (cmd_ready[p] !== 1'b1 && n < 50);
    cmd_valid[p] <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while (rsp_valid[p] !== 1'b1 && n < 60);
    if (rsp_valid[p] !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
    q = rsp_rdata[p];
    e = rsp_err[p];
  endtask : run_cmd

  task automatic wr(input int p, input size_t s, input logic [31:0] a, d);
    logic [31:0] q;
    logic        e;
    run_cmd(p, 1'b1, s, a, d, q, e);
    check_flag(e, 1'b0);
  endtask : wr

  task automatic rd(input int p, input size_t s, input logic [31:0] a, x);
    logic [31:0] q;
    logic        e;
    run_cmd(p, 1'b0, s, a, 32'h0000_0000, q, e);
    check_data(q, x);
  endtask : rd

  task automatic refuse(input int p, input size_t s, input logic [31:0] a);
    logic [31:0] q;
    logic        e;
    run_cmd(p, 1'b1, s, a, 32'h0000_0000, q, e);
    check_flag(e, 1'b1);
  endtask : refuse

  task automatic s_words;
    wr(BUS_I, SZ_WORD, 32'h0500_7004, 32'h1122_3344);
    rd(BUS_L, SZ_WORD, 32'hA500_7004, 32'h1122_3344);
    wr(BUS_L, SZ_WORD, 32'hA501_8FFC, 32'h5566_7788);
    rd(BUS_I, SZ_WORD, 32'h0501_8FFC, 32'h5566_7788);
  endtask : s_words

  task automatic s_lanes;
    wr(BUS_L, SZ_BYTE, 32'hA500_7005, 32'h00AB_0000);
    wr(BUS_I, SZ_HALF, 32'h0500_7006, 32'h0000_CDEF);
    rd(BUS_I, SZ_WORD, 32'h0500_7004, 32'h11AB_CDEF);
  endtask : s_lanes

  task automatic s_operand;
    fork
      rd(BUS_X, SZ_HALF, 32'h0000_7004, 32'h0000_11AB);
      rd(BUS_Y, SZ_HALF, 32'h0000_8FFE, 32'h0000_7788);
    join
    wr(BUS_X, SZ_HALF, 32'h0000_7006, 32'h0000_BEEF);
    rd(BUS_I, SZ_WORD, 32'h0500_7004, 32'h11AB_BEEF);
  endtask : s_operand

  // same page from two buses, then two banks at once
  task automatic s_contend;
    fork
      rd(BUS_I, SZ_WORD, 32'h0500_7004, 32'h11AB_BEEF);
      rd(BUS_L, SZ_WORD, 32'hA500_7004, 32'h11AB_BEEF);
    join
    fork
      rd(BUS_I, SZ_WORD, 32'h0500_7004, 32'h11AB_BEEF);
      rd(BUS_L, SZ_WORD, 32'hA501_8FFC, 32'h5566_7788);
    join
  endtask : s_contend

  task automatic s_dma;
    @(posedge clock);
    dma_active <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check_flag(cmd_ready[BUS_L], 1'b0);
    check_flag(cmd_ready[BUS_Y], 1'b0);
    rd(BUS_I, SZ_BYTE, 32'h0500_7004, 32'h11AB_BEEF);
    @(posedge clock);
    dma_active <= 1'b0;
  endtask : s_dma

  task automatic s_refuse;
    @(posedge clock);
    cache_on <= 1'b1;
    refuse(BUS_I, SZ_WORD, 32'h0500_7004);
    @(posedge clock);
    cache_on <= 1'b0;
    l_dsp    <= 1'b1;
    refuse(BUS_L, SZ_BYTE, 32'hA500_7004);
    @(posedge clock);
    l_dsp    <= 1'b0;
    refuse(BUS_I, SZ_WORD, 32'h8500_7004);
    refuse(BUS_I, SZ_WORD, 32'h0500_9000);
  endtask : s_refuse

  initial begin
    rst = 1'b1;
    {cache_on, dma_active, l_dsp} = 3'h0;
    num_errors  = 0;
    comparisons = 0;
    for (int p = 0; p < NBUS; p++) begin
      cmd_valid[p] = 1'b0;
      cmd_we[p]    = 1'b0;
      cmd_size[p]  = SZ_WORD;
      cmd_addr[p]  = 32'h0000_0000;
      cmd_wdata[p] = 32'h0000_0000;
    end
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    s_words();
    s_lanes();
    s_operand();
    s_contend();
    s_dma();
    s_refuse();
    report_and_stop();
  end
endmodule : dual_bank_multiport_ram_tb_top
